// >>> mrl_apb.v
// APB slave: control, status and completion count.
// Assumes an APB master on CLK_SYS; no wait states.
`timescale 1ns/1ps
`include "mrl_defs.vh"

module mrl_apb (
    input  wire        clk,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        busy,
    input  wire [2:0]  last_event,
    input  wire        done,
    output wire        legacy,
    output wire        mode64,
    output wire        align_trap
);
    reg  [2:0]  ctrl_reg;
    reg  [31:0] count_reg;
    reg  [31:0] prdata_reg;
    reg         pready_reg;
    reg         pslverr_reg;
    reg  [31:0] rd_next;
    reg         err_next;

    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign legacy     = ctrl_reg[`MRL_CTRL_LEGACY];
    assign mode64     = ctrl_reg[`MRL_CTRL_MODE64];
    assign align_trap = ctrl_reg[`MRL_CTRL_ATRAP];

    // ****************************************************************
    // Read mux and unmapped address detection
    // ****************************************************************
    always @*
    begin
        rd_next  = 32'h0;
        err_next = 1'b0;
        if (paddr == `MRL_ADDR_CTRL)
            rd_next = {29'h0, ctrl_reg};
        else if (paddr == `MRL_ADDR_STATUS)
            rd_next = {25'h0, last_event, 3'h0, busy};
        else if (paddr == `MRL_ADDR_COUNT)
            rd_next = count_reg;
        else
            err_next = 1'b1;
    end

    // Answer latched in setup, so pready is high at the first access edge
    always @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_reg    <= `MRL_CTRL_RST;
            count_reg   <= 32'h0;
            prdata_reg  <= 32'h0;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= psel && !penable;
            pslverr_reg <= psel && !penable && err_next;
            prdata_reg  <= (psel && !penable && !pwrite) ? rd_next : 32'h0;
            if (psel && penable && pready_reg && pwrite && paddr == `MRL_ADDR_CTRL)
                ctrl_reg <= pwdata[2:0];
            if (done)
                count_reg <= count_reg + 32'h1;
        end
    end

endmodule

// >>> mrl_decode.v
// Decode and effective address of the load unit.
// Assumes the caller reads operands.
`timescale 1ns/1ps
`include "mrl_defs.vh"

module mrl_decode (
    input  wire [31:0] instr,
    input  wire [63:0] base_val,
    input  wire [63:0] index_val,
    input  wire        legacy,
    input  wire        mode64,
    output reg  [1:0]  op,
    output reg         illegal,
    output wire [4:0]  rt,
    output wire [4:0]  ra,
    output wire [4:0]  rb,
    output wire        rc,
    output wire [63:0] ea
);
    wire [5:0]  prim = instr[`MRL_PRIM_HI:`MRL_PRIM_LO];
    wire [9:0]  xo   = instr[`MRL_XO_HI:`MRL_XO_LO];
    wire [63:0] base = (ra != 5'h00) ? base_val : 64'h0;
    reg  [63:0] sum;

    assign rt = instr[`MRL_RT_HI:`MRL_RT_LO];
    assign ra = instr[`MRL_RA_HI:`MRL_RA_LO];
    assign rb = instr[`MRL_RB_HI:`MRL_RB_LO];
    assign rc = instr[`MRL_RC_BIT];
    // Narrow mode wraps at 32 bits
    assign ea = mode64 ? sum : {32'h0, sum[31:0]};

    // ****************************************************************
    // Opcode match and address sum
    // ****************************************************************
    always @*
    begin
        op      = `MRL_OP_LMW;
        illegal = 1'b1;
        sum     = 64'h0;
        if (prim == `MRL_PRIM_LMW)                                      // [RQ2]
        begin
            illegal = 1'b0;
            sum     = base + {{48{instr[15]}}, instr[15:0]};            // [RQ3]
        end
        else if (prim == `MRL_PRIM_LQ)                                  // [RQ9]
        begin
            op      = `MRL_OP_LQ;
            // Narrow core, odd target or nonzero low bits trap
            illegal = !mode64 || rt[0] || (instr[3:0] != 4'h0);         // [RQ12] [RQ13]
            sum     = base + {{52{instr[`MRL_DQ_HI]}},
                              instr[`MRL_DQ_HI:`MRL_DQ_LO]} * 64'h10;   // [RQ11]
        end
        else if (prim == `MRL_PRIM_X && xo == `MRL_XO_LSCBX && legacy)  // [RQ14]
        begin
            op      = `MRL_OP_LSCBX;
            illegal = 1'b0;
            sum     = base + index_val;                                 // [RQ16]
        end
    end

endmodule

// >>> mrl_defs.vh
// Opcodes, field positions, sizes, register map and resets of the load unit.
// Assumes each design file includes it once.
`ifndef MRL_DEFS_VH
`define MRL_DEFS_VH

// ****************************************************************
// Instruction encodings
// ****************************************************************
`define MRL_PRIM_LMW     6'h2E
`define MRL_PRIM_LQ      6'h38
`define MRL_PRIM_X       6'h1F
`define MRL_XO_LSCBX     10'h115
`define MRL_PRIM_HI      31
`define MRL_PRIM_LO      26
`define MRL_RT_HI        25
`define MRL_RT_LO        21
`define MRL_RA_HI        20
`define MRL_RA_LO        16
`define MRL_RB_HI        15
`define MRL_RB_LO        11
`define MRL_XO_HI        10
`define MRL_XO_LO        1
`define MRL_RC_BIT       0
`define MRL_DQ_HI        15
`define MRL_DQ_LO        4
`define MRL_LAST_GPR     5'h1F

// Operation codes handed from decode to the sequencer
`define MRL_OP_LMW       2'h0
`define MRL_OP_LQ        2'h1
`define MRL_OP_LSCBX     2'h2

// Storage request sizes
`define MRL_SIZE_BYTE    2'h0
`define MRL_SIZE_WORD    2'h2
`define MRL_SIZE_QUAD    2'h3

// Last event codes shown in the status register
`define MRL_EV_NONE      3'h0
`define MRL_EV_DONE      3'h1
`define MRL_EV_ALIGN     3'h2
`define MRL_EV_ILLEGAL   3'h3
`define MRL_EV_DSI       3'h4

// ****************************************************************
// APB register map
// ****************************************************************
`define MRL_ADDR_CTRL    12'h000
`define MRL_ADDR_STATUS  12'h004
`define MRL_ADDR_COUNT   12'h008
`define MRL_CTRL_LEGACY  0
`define MRL_CTRL_MODE64  1
`define MRL_CTRL_ATRAP   2
`define MRL_CTRL_RST     3'h7

`endif

// >>> mrl_mem_model.sv
// Storage model: answers reads after lat cycles, faults address bad.
// Assumes requests stand until answered.
`timescale 1ns/1ps
module mrl_mem_model (
    input  wire         clk,
    input  wire         req,
    input  wire [63:0]  addr,
    input  wire [1:0]   size,
    input  wire [3:0]   lat,
    input  wire [63:0]  bad,
    output reg          ack,
    output reg          dsi,
    output reg  [127:0] rdata
);
    reg [3:0] n;
    initial {ack, dsi, rdata, n} = 0;
    // Answer after lat waits; data churns between answers
    always @(posedge clk)
    begin
        ack   <= 1'b0;
        dsi   <= 1'b0;
        rdata <= ~rdata;
        if (req && !ack && !dsi)
        begin
            n <= (n < lat) ? n + 4'h1 : 4'h0;
            if (n >= lat)
            begin
                dsi   <= (addr == bad);
                ack   <= (addr != bad);
                rdata <= (size == 2'h3) ? {addr, ~addr} : {96'h0, addr[31:0] ^ 32'h5A5A0000};
            end
        end
    end
endmodule

// >>> mrl_unit.v
// Multi-register load unit: sequences
// multi-register loads, one write per cycle.
// Assumes operands come with the instruction and
// storage answers each request once.
//
// Behaviour
// RQ1 - Word-multiple load fills target register through register 31, one word each.
// RQ2 - Word-multiple load is primary opcode 46 with target, base, displacement.
// RQ3 - Word-multiple address is base plus sign-extended displacement, or displacement alone.
// RQ4 - Newer variant: base inside range or both zero gives undefined results.
// RQ5 - Word-multiple address must be word aligned, else alignment trap or undefined.
// RQ6 - Legacy variant skips writing a nonzero base register inside the range.
// RQ7 - Word-multiple load leaves exception register and condition field zero alone.
// RQ8 - Data-storage fault aborts word-multiple load; reissue restarts from the first word.
// RQ9 - Quadword load is primary opcode 56, 12-bit displacement, low four bits zero.
// RQ10 - Quadword load writes 128 bits into target and the following register.
// RQ11 - Quadword address is base plus displacement sign-extended and times 16.
// RQ12 - Odd quadword target register is an invalid form.
// RQ13 - Quadword load exists only in 64-bit mode; otherwise illegal instruction.
// RQ14 - Legacy only: string-compare load is opcode 31, extended 277, record bit.
// RQ15 - String load fills bytes leftmost first, wraps 31 to 0, stops on match.
// RQ16 - String address is base plus index, or index alone when base field zero.
// RQ17 - Byte count from exception register; bytes loaded written back there.
// RQ18 - Zero starting count leaves the target register unaltered.
// RQ19 - After the matching byte no more storage reads are issued.
// RQ20 - Nonzero base or index register in range is skipped, loading continues. The code skips the index register only when the base field is nonzero.
// RQ21 - Record bit sets condition field zero to 00, match, summary overflow.
// RQ22 - Data-storage fault restarts string load with original count and address.
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mrl_defs.vh"

module mrl_unit (
    input  wire         CLK_SYS,
    input  wire         SRST,
    // Instruction issue
    input  wire         ISSUE_VALID,
    input  wire [31:0]  ISSUE_INSTR,
    input  wire [63:0]  ISSUE_BASE,
    input  wire [63:0]  ISSUE_INDEX,
    input  wire [7:0]   XER_CMP_BYTE,
    input  wire [6:0]   XER_COUNT_IN,
    input  wire         XER_SO,
    output wire         ISSUE_READY,
    // Storage read path
    output wire         MEM_REQ,
    output wire [63:0]  MEM_ADDR,
    output wire [1:0]   MEM_SIZE,
    input  wire         MEM_ACK,
    input  wire         MEM_DSI,
    input  wire [127:0] MEM_RDATA,
    // Register file and special register writes
    output wire         GPR_WE,
    output wire [4:0]   GPR_WADDR,
    output wire [63:0]  GPR_WDATA,
    output wire         XER_WE,
    output wire [6:0]   XER_COUNT_OUT,
    output wire         CR0_WE,
    output wire [3:0]   CR0_OUT,
    // Completion and exceptions
    output wire         DONE,
    output wire         EXC_ALIGN,
    output wire         EXC_ILLEGAL,
    output wire         EXC_DSI,
    // APB
    input  wire         PSEL,
    input  wire         PENABLE,
    input  wire         PWRITE,
    input  wire [11:0]  PADDR,
    input  wire [31:0]  PWDATA,
    output wire [31:0]  PRDATA,
    output wire         PREADY,
    output wire         PSLVERR
);
    // ****************************************************************
    // State codes
    // ****************************************************************
    localparam S_IDLE = 2'h0;
    localparam S_REQ  = 2'h1;
    localparam S_LQ2  = 2'h2;
    localparam S_END  = 2'h3;

    reg  [1:0]   state_reg;
    reg  [1:0]   op_reg;
    reg  [4:0]   ra_reg;
    reg  [4:0]   rb_reg;
    reg          rc_reg;
    reg          legacy_reg;
    reg  [4:0]   cur_reg;
    reg  [1:0]   pos_reg;
    reg  [31:0]  acc_reg;
    reg  [6:0]   left_reg;
    reg  [6:0]   loaded_reg;
    reg          match_reg;
    reg  [7:0]   cmp_reg;
    reg          so_reg;
    reg  [63:0]  lo_reg;
    reg  [2:0]   event_reg;
    reg          ready_reg;
    reg          mem_req_reg;
    reg  [63:0]  mem_addr_reg;
    reg  [1:0]   mem_size_reg;
    reg          gpr_we_reg;
    reg  [4:0]   gpr_waddr_reg;
    reg  [63:0]  gpr_wdata_reg;
    reg          xer_we_reg;
    reg  [6:0]   xer_count_reg;
    reg          cr0_we_reg;
    reg  [3:0]   cr0_reg;
    reg          done_reg;
    reg          exc_align_reg;
    reg          exc_illegal_reg;
    reg          exc_dsi_reg;

    wire [1:0]   dec_op;
    wire         dec_illegal;
    wire [4:0]   dec_rt;
    wire [4:0]   dec_ra;
    wire [4:0]   dec_rb;
    wire         dec_rc;
    wire [63:0]  dec_ea;
    wire         legacy;
    wire         mode64;
    wire         align_trap;

    assign ISSUE_READY   = ready_reg;
    assign MEM_REQ       = mem_req_reg;
    assign MEM_ADDR      = mem_addr_reg;
    assign MEM_SIZE      = mem_size_reg;
    assign GPR_WE        = gpr_we_reg;
    assign GPR_WADDR     = gpr_waddr_reg;
    assign GPR_WDATA     = gpr_wdata_reg;
    assign XER_WE        = xer_we_reg;
    assign XER_COUNT_OUT = xer_count_reg;
    assign CR0_WE        = cr0_we_reg;
    assign CR0_OUT       = cr0_reg;
    assign DONE          = done_reg;
    assign EXC_ALIGN     = exc_align_reg;
    assign EXC_ILLEGAL   = exc_illegal_reg;
    assign EXC_DSI       = exc_dsi_reg;

    // ****************************************************************
    // Submodules
    // ****************************************************************
    mrl_decode u_decode (
        .instr     (ISSUE_INSTR),
        .base_val  (ISSUE_BASE),
        .index_val (ISSUE_INDEX),
        .legacy    (legacy),
        .mode64    (mode64),
        .op        (dec_op),
        .illegal   (dec_illegal),
        .rt        (dec_rt),
        .ra        (dec_ra),
        .rb        (dec_rb),
        .rc        (dec_rc),
        .ea        (dec_ea)
    );

    mrl_apb u_apb (
        .clk        (CLK_SYS),
        .srst       (SRST),
        .psel       (PSEL),
        .penable    (PENABLE),
        .pwrite     (PWRITE),
        .paddr      (PADDR),
        .pwdata     (PWDATA),
        .prdata     (PRDATA),
        .pready     (PREADY),
        .pslverr    (PSLVERR),
        .busy       (state_reg != S_IDLE),
        .last_event (event_reg),
        .done       (done_reg),
        .legacy     (legacy),
        .mode64     (mode64),
        .align_trap (align_trap)
    );

    // ****************************************************************
    // Data path helpers
    // ****************************************************************
    // Legacy variant discards writes to a nonzero base, and to the string index only when the base is nonzero
    wire discard = legacy_reg && (ra_reg != 5'h00) &&
                   ((cur_reg == ra_reg) ||
                    (op_reg == `MRL_OP_LSCBX && cur_reg == rb_reg));  // [RQ6] [RQ20]
    wire [7:0]  byte_in  = MEM_RDATA[7:0];
    wire [31:0] acc_new  = acc_reg | ({24'h0, byte_in} << {~pos_reg, 3'h0}); // [RQ15]
    wire        hit      = (byte_in == cmp_reg);
    wire        last     = (left_reg == 7'h01);
    wire        issue    = ready_reg && ISSUE_VALID;
    wire        misalign = (dec_ea[1:0] != 2'h0) && align_trap;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    always @(posedge CLK_SYS)
    begin
        if (SRST)
        begin
            state_reg       <= S_IDLE;
            op_reg          <= `MRL_OP_LMW;
            ra_reg          <= 5'h00;
            rb_reg          <= 5'h00;
            rc_reg          <= 1'b0;
            legacy_reg      <= 1'b0;
            cur_reg         <= 5'h00;
            pos_reg         <= 2'h0;
            acc_reg         <= 32'h0;
            left_reg        <= 7'h00;
            loaded_reg      <= 7'h00;
            match_reg       <= 1'b0;
            cmp_reg         <= 8'h00;
            so_reg          <= 1'b0;
            lo_reg          <= 64'h0;
            event_reg       <= `MRL_EV_NONE;
            ready_reg       <= 1'b0;
            mem_req_reg     <= 1'b0;
            mem_addr_reg    <= 64'h0;
            mem_size_reg    <= `MRL_SIZE_BYTE;
            gpr_we_reg      <= 1'b0;
            gpr_waddr_reg   <= 5'h00;
            gpr_wdata_reg   <= 64'h0;
            xer_we_reg      <= 1'b0;
            xer_count_reg   <= 7'h00;
            cr0_we_reg      <= 1'b0;
            cr0_reg         <= 4'h0;
            done_reg        <= 1'b0;
            exc_align_reg   <= 1'b0;
            exc_illegal_reg <= 1'b0;
            exc_dsi_reg     <= 1'b0;
        end
        else
        begin
            // Pulses last one cycle
            gpr_we_reg      <= 1'b0;
            xer_we_reg      <= 1'b0;
            cr0_we_reg      <= 1'b0;
            done_reg        <= 1'b0;
            exc_align_reg   <= 1'b0;
            exc_illegal_reg <= 1'b0;
            exc_dsi_reg     <= 1'b0;
            case (state_reg)
            S_IDLE:
            begin
                ready_reg <= !issue;
                if (issue)
                begin
                    // Operands captured once; a restart brings them again
                    op_reg       <= dec_op;
                    ra_reg       <= dec_ra;
                    rb_reg       <= dec_rb;
                    rc_reg       <= dec_rc;
                    legacy_reg   <= legacy;
                    cur_reg      <= dec_rt;
                    pos_reg      <= 2'h0;
                    acc_reg      <= 32'h0;
                    left_reg     <= XER_COUNT_IN;                      // [RQ17]
                    loaded_reg   <= 7'h00;
                    match_reg    <= 1'b0;
                    cmp_reg      <= XER_CMP_BYTE;
                    so_reg       <= XER_SO;
                    mem_addr_reg <= dec_ea;
                    if (dec_illegal)
                    begin
                        exc_illegal_reg <= 1'b1;                       // [RQ13]
                        event_reg       <= `MRL_EV_ILLEGAL;
                        ready_reg       <= 1'b1;
                    end
                    else if (dec_op == `MRL_OP_LMW && misalign)
                    begin
                        exc_align_reg <= 1'b1;                         // [RQ5]
                        event_reg     <= `MRL_EV_ALIGN;
                        ready_reg     <= 1'b1;
                    end
                    else if (dec_op == `MRL_OP_LSCBX && XER_COUNT_IN == 7'h00)
                        state_reg <= S_END;                            // [RQ18]
                    else
                    begin
                        state_reg    <= S_REQ;
                        mem_req_reg  <= 1'b1;
                        mem_size_reg <= (dec_op == `MRL_OP_LMW) ? `MRL_SIZE_WORD :
                                        (dec_op == `MRL_OP_LQ)  ? `MRL_SIZE_QUAD :
                                                                  `MRL_SIZE_BYTE;
                    end
                end
            end
            S_REQ:
            begin
                if (MEM_DSI)
                begin
                    // Abort; FIXED_POINT_EXCEPTION_REGISTER untouched so a reissue starts over
                    mem_req_reg <= 1'b0;
                    exc_dsi_reg <= 1'b1;                               // [RQ8] [RQ22]
                    event_reg   <= `MRL_EV_DSI;
                    state_reg   <= S_IDLE;
                    ready_reg   <= 1'b1;
                end
                else if (MEM_ACK)
                begin
                    if (op_reg == `MRL_OP_LMW)
                    begin
                        // Newer variant writes every register in range
                        gpr_we_reg    <= !discard;                     // [RQ4] [RQ6]
                        gpr_waddr_reg <= cur_reg;
                        gpr_wdata_reg <= {32'h0, MEM_RDATA[31:0]};     // [RQ1]
                        cur_reg       <= cur_reg + 5'h01;
                        mem_addr_reg  <= mem_addr_reg + 64'h4;
                        if (cur_reg == `MRL_LAST_GPR)
                        begin
                            mem_req_reg <= 1'b0;
                            state_reg   <= S_END;
                        end
                    end
                    else if (op_reg == `MRL_OP_LQ)
                    begin
                        // High doubleword to the even register first
                        gpr_we_reg    <= 1'b1;                         // [RQ10]
                        gpr_waddr_reg <= cur_reg;
                        gpr_wdata_reg <= MEM_RDATA[127:64];
                        lo_reg        <= MEM_RDATA[63:0];
                        cur_reg       <= cur_reg + 5'h01;
                        mem_req_reg   <= 1'b0;
                        state_reg     <= S_LQ2;
                    end
                    else
                    begin
                        acc_reg    <= acc_new;
                        pos_reg    <= pos_reg + 2'h1;
                        left_reg   <= left_reg - 7'h01;
                        loaded_reg <= loaded_reg + 7'h01;              // [RQ17]
                        match_reg  <= hit;
                        mem_addr_reg <= mem_addr_reg + 64'h1;
                        if (pos_reg == 2'h3 || hit || last)
                        begin
                            // Register closes; unloaded bytes read as zero
                            gpr_we_reg    <= !discard;                 // [RQ20]
                            gpr_waddr_reg <= cur_reg;
                            gpr_wdata_reg <= {32'h0, acc_new};
                            cur_reg       <= cur_reg + 5'h01;          // [RQ15]
                            acc_reg       <= 32'h0;
                            pos_reg       <= 2'h0;
                        end
                        if (hit || last)
                        begin
                            // No storage read follows a match
                            mem_req_reg <= 1'b0;                       // [RQ19]
                            state_reg   <= S_END;
                        end
                    end
                end
            end
            S_LQ2:
            begin
                gpr_we_reg    <= 1'b1;                                 // [RQ10]
                gpr_waddr_reg <= cur_reg;
                gpr_wdata_reg <= lo_reg;
                state_reg     <= S_END;
            end
            default:
            begin
                // Only the string load touches FIXED_POINT_EXCEPTION_REGISTER and condition field
                if (op_reg == `MRL_OP_LSCBX)                           // [RQ7]
                begin
                    xer_we_reg    <= 1'b1;                             // [RQ17]
                    xer_count_reg <= loaded_reg;
                    cr0_we_reg    <= rc_reg;                           // [RQ21]
                    cr0_reg       <= {2'b00, match_reg, so_reg};
                end
                done_reg  <= 1'b1;
                event_reg <= `MRL_EV_DONE;
                state_reg <= S_IDLE;
                ready_reg <= 1'b1;
            end
            endcase
        end
    end

endmodule

// >>> mrl_unit_monitor.sv
// Checker for the load unit, bound to mrl_unit.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
module mrl_unit_monitor (
    input wire CLK_SYS, SRST, ISSUE_VALID, ISSUE_READY, MEM_REQ, MEM_ACK, MEM_DSI,
    input wire GPR_WE, XER_WE, CR0_WE, DONE, EXC_ALIGN, EXC_ILLEGAL, EXC_DSI,
    input wire [31:0] ISSUE_INSTR,
    input wire [63:0] MEM_ADDR,
    input wire [1:0] MEM_SIZE
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SRST);
    wire tk = ISSUE_VALID && ISSUE_READY;
    wire lm = tk && ISSUE_INSTR[31:26] == 6'h2E;
    reg [15:0] d_q;
    // Displacement of the instruction just offered
    always @(posedge CLK_SYS) d_q <= ISSUE_INSTR[15:0];
    chk_ready_drop: assert property (tk |=> !ISSUE_READY || EXC_ILLEGAL || EXC_ALIGN)
        else $error("ready held");
    chk_lmw_addr: assert property (lm && ISSUE_INSTR[20:15] == 0 && ISSUE_INSTR[1:0] == 0
        |=> MEM_REQ && MEM_ADDR == {48'h0, d_q}) else $error("word address");
    chk_req_hold: assert property (MEM_REQ && !MEM_ACK && !MEM_DSI
        |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_SIZE)) else $error("request dropped");
    chk_lq_pair: assert property (MEM_REQ && MEM_ACK && MEM_SIZE == 2'h3
        |=> GPR_WE ##1 GPR_WE ##1 DONE) else $error("quad writes wrong");
    chk_lq_odd: assert property (tk && ISSUE_INSTR[31:26] == 6'h38 && ISSUE_INSTR[21]
        |=> EXC_ILLEGAL) else $error("odd quad taken");
    chk_dsi_exc: assert property (MEM_REQ && MEM_DSI |=> EXC_DSI && !MEM_REQ)
        else $error("fault not reported");
    chk_dsi_quiet: assert property (MEM_REQ && MEM_DSI
        |=> (!GPR_WE && !XER_WE && !CR0_WE)[*2]) else $error("write after fault");
    chk_lmw_noxer: assert property (lm |=> (!XER_WE && !CR0_WE)[*6])
        else $error("word load wrote count");
endmodule
bind mrl_unit mrl_unit_monitor mrl_unit_monitor_i (.*);

// >>> mrl_unit_tb_top.sv
// Self-checking bench for the load unit.
// Assumes the storage model answers; APB by tasks.
`timescale 1ns/1ps
module mrl_unit_tb_top;
    reg clk = 0, srst = 1, iv = 0, so = 0, psel = 0, pen = 0, pwr = 0;
    reg [31:0] ins = 0, pwd = 0, r, lw;
    reg [63:0] ba = 0, ix = 0, bad = '1;
    reg [7:0] cmp = 0;
    reg [6:0] cnt = 0, xv;
    reg [11:0] pa = 0;
    reg [3:0] lat = 0, cv, ev;
    reg e;
    wire ir, mr, ack, dsi, we, xwe, cwe, dn, ea, ei, ed, prdy, perr;
    wire [63:0] ma, wd;
    wire [1:0] ms;
    wire [127:0] rd;
    wire [4:0] wa;
    wire [6:0] xo;
    wire [3:0] co;
    wire [31:0] prd;
    logic [63:0] gpr [32];
    reg [31:0] wm;
    int n_mismatch = 0, check_count = 0;
    always #4 clk = ~clk;
    mrl_unit mrl_unit_i (.CLK_SYS(clk), .SRST(srst), .ISSUE_VALID(iv), .ISSUE_INSTR(ins),
        .ISSUE_BASE(ba), .ISSUE_INDEX(ix), .XER_CMP_BYTE(cmp), .XER_COUNT_IN(cnt), .XER_SO(so),
        .ISSUE_READY(ir), .MEM_REQ(mr), .MEM_ADDR(ma), .MEM_SIZE(ms), .MEM_ACK(ack),
        .MEM_DSI(dsi), .MEM_RDATA(rd), .GPR_WE(we), .GPR_WADDR(wa), .GPR_WDATA(wd),
        .XER_WE(xwe), .XER_COUNT_OUT(xo), .CR0_WE(cwe), .CR0_OUT(co), .DONE(dn),
        .EXC_ALIGN(ea), .EXC_ILLEGAL(ei), .EXC_DSI(ed), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));
    mrl_mem_model mrl_mem_model_i (.clk(clk), .req(mr), .addr(ma), .size(ms), .lat(lat),
        .bad(bad), .ack(ack), .dsi(dsi), .rdata(rd));
    // Shadow register file, count, field and completion event
    always @(posedge clk)
    begin
        if (we) {gpr[wa], wm[wa]} <= {wd, 1'b1};
        if (xwe) xv <= xo;
        if (cwe) cv <= co;
        if (dn | ea | ei | ed) ev <= {ed, ei, ea, dn};
    end
    task chk(input logic [63:0] g, x);
        check_count++;
        if (g !== x) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, g, x); end
    endtask
    task give_verdict;
        if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task hang(input int k);
        if (k >= 99) begin n_mismatch++; give_verdict; end
    endtask
    // APB setup, then access until ready
    task automatic apb(input w, input [11:0] a, input [31:0] d);
        int k = 0;
        @(posedge clk); {psel, pwr, pa, pwd} <= {1'b1, w, a, d};
        @(posedge clk); pen <= 1;
        do begin @(posedge clk); k++; end while (prdy !== 1 && k < 99);
        hang(k); r = prd; e = perr; psel <= 0; pen <= 0;
    endtask
    // Issue one instruction, await its end
    task automatic run(input [31:0] i, input [63:0] b, input [63:0] x, input [3:0] exp_ev);
        int k = 0;
        @(posedge clk); {ins, ba, ix, iv, wm, ev} <= {i, b, x, 1'b1, 32'h0, 4'h0};
        @(posedge clk);
        while (ir !== 1 && k < 99) begin @(posedge clk); k++; end
        hang(k); iv <= 0; k = 0;
        while (ev == 0 && k < 99) begin @(posedge clk); k++; end
        hang(k); chk(ev, exp_ev);
    endtask
    initial
    begin
        lw = {6'd46, 5'd30, 5'd0, 16'h0100};
        repeat (20) @(posedge clk);
        srst <= 0;
        apb(0, 12'h000, 0); chk(r, 7);
        apb(0, 12'h00C, 0); chk(e, 1);
        run(lw, 0, 0, 1); chk(gpr[30], 64'h5A5A0100); chk(gpr[31], 64'h5A5A0104);
        lat <= 2; bad <= 64'h104; run(lw, 0, 0, 8);
        bad <= '1; run(lw, 0, 0, 1); chk(wm, 32'hC0000000);
        run({6'd46, 5'd29, 5'd30, 16'h0}, 64'h200, 0, 1); chk(wm, 32'hA0000000);
        run({6'd46, 5'd30, 5'd0, 16'h0102}, 0, 0, 2);
        run({6'd56, 5'd4, 5'd5, 12'h001, 4'h0}, 64'h1000, 0, 1); chk(gpr[5], ~64'h1010);
        chk(gpr[4], 64'h1010);
        run({6'd56, 5'd5, 5'd0, 16'h0010}, 0, 0, 4);
        cmp <= 3; cnt <= 9; lw = {6'd31, 5'd6, 5'd0, 5'd1, 10'd277, 1'b1};
        run(lw, 0, 64'h2001, 1); chk(gpr[6], 64'h01020300); chk(xv, 3); chk(cv, 2);
        cnt <= 0; run(lw, 0, 64'h2001, 1); chk(wm, 0); chk(xv, 0);
        apb(1, 12'h000, 1); run({6'd56, 5'd4, 5'd0, 16'h0010}, 0, 0, 4);
        give_verdict;
    end
endmodule
